// *** logic/rtc_event_flag_status.sv ***
// event flag status register with periodic timer and alarm flag capture
// Notes on behaviour
// R1: the flag register answers at register address 2Bh.
// R2: bit 7 reads 1 while the periodic event flag is pending, else 0.
// R3: writing 0 to bit 7 clears the periodic event flag.
// R4: writing 1 to bit 7 leaves the periodic event flag as it was.
// R5: bit 6 reads 1 while the second alarm flag is pending.
// R6: bit 6 reads 0 when no second alarm event is pending.
// R7: writing 0 to bit 6 clears the second alarm flag.
// R8: the periodic event flag is set each time the selected periodic timer fires.
// R9: periodic pulses keep coming whether or not the flag was cleared.
// R10: writing 1 to bit 6 leaves the second alarm flag as it was.
`include "rtc_flags_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rtc_event_flag_status (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  input  wire logic                         i_ce,
  input  wire logic                         i_sec_tick,
  input  wire logic                         i_alarm2_match,
  input  wire rtc_flags_pkg::periodic_sel_t i_periodic_sel,
  input  wire logic [7:0]                   i_addr,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  input  wire logic [7:0]                   i_wdata,
  output logic [7:0]                        o_rdata,
  output logic                              o_periodic_event_flag,
  output logic                              o_second_alarm_flag,
  output logic                              o_periodic_pulse
);
  import rtc_flags_pkg::*;

  flag_state_t state_r;
  flag_state_t state_nxt;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // one decode shared by the write and read paths
  function automatic logic hits_flag_reg(input logic [7:0] addr);
    return addr == `FLAG_REG_ADDR;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic sec_edge;
    logic alm_edge;
    logic fire;
    logic hit;
    logic [7:0] rd_val;
    sec_edge = 1'b0;
    alm_edge = 1'b0;
    fire = 1'b0;
    hit = 1'b0;
    rd_val = 8'h00;
    state_nxt = state_r;
    // pins from the time base domain: two flops before use
    state_nxt.sec_s1 = i_sec_tick;
    state_nxt.sec_s2 = state_r.sec_s1;
    state_nxt.sec_s3 = state_r.sec_s2;
    state_nxt.alm_s1 = i_alarm2_match;
    state_nxt.alm_s2 = state_r.alm_s1;
    state_nxt.alm_s3 = state_r.alm_s2;
    sec_edge = state_r.sec_s2 & ~state_r.sec_s3;
    alm_edge = state_r.alm_s2 & ~state_r.alm_s3;
    // disabled timers are held reset
    if (i_periodic_sel == `PERIODIC_NONE) begin
      state_nxt.sec_cnt = 6'h00;
      state_nxt.min_cnt = 6'h00;
    end else if (sec_edge) begin
      hit = (i_periodic_sel == `PERIODIC_SECOND);
      if (state_r.sec_cnt == `SECS_PER_MIN) begin
        state_nxt.sec_cnt = 6'h00;
        if (i_periodic_sel == `PERIODIC_MINUTE) begin
          hit = 1'b1;
        end
        if (state_r.min_cnt == `MINS_PER_HOUR) begin
          state_nxt.min_cnt = 6'h00;
          if (i_periodic_sel == `PERIODIC_HOUR) begin
            hit = 1'b1;
          end
        end else begin
          state_nxt.min_cnt = 6'(state_r.min_cnt + 6'h01);
        end
      end else begin
        state_nxt.sec_cnt = 6'(state_r.sec_cnt + 6'h01);
      end
    end
    fire = hit;
    // R9 pulse independent of flag
    state_nxt.pulse = fire;
    // R1 address decode
    if (i_wr && hits_flag_reg(i_addr)) begin
      // R3 write zero clears
      // R4 write one keeps
      if (!i_wdata[`PERIODIC_FLAG_BIT]) begin
        state_nxt.periodic_event_flag = 1'b0;
      end
      // R7 write zero clears
      // R10 write one keeps
      if (!i_wdata[`ALARM2_FLAG_BIT]) begin
        state_nxt.second_alarm_flag = 1'b0;
      end
    end
    // R8 timer sets flag; set beats clear
    if (fire) begin
      state_nxt.periodic_event_flag = 1'b1;
    end
    // set beats clear for the alarm as well
    if (alm_edge) begin
      state_nxt.second_alarm_flag = 1'b1;
    end
    // R2 periodic flag on bit 7
    rd_val[`PERIODIC_FLAG_BIT] = state_r.periodic_event_flag;
    // R5 alarm flag on bit 6
    // R6 reads zero when idle
    rd_val[`ALARM2_FLAG_BIT] = state_r.second_alarm_flag;
    if (i_rd) begin
      state_nxt.rdata = hits_flag_reg(i_addr) ? rd_val : 8'h00;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= '0;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  assign o_rdata               = state_r.rdata;
  assign o_periodic_event_flag = state_r.periodic_event_flag;
  assign o_second_alarm_flag   = state_r.second_alarm_flag;
  assign o_periodic_pulse      = state_r.pulse;
endmodule
`default_nettype wire

// *** logic/rtc_flags_consts.svh ***
// constants of the event flag status register
`ifndef RTC_FLAGS_CONSTS_SVH
`define RTC_FLAGS_CONSTS_SVH
`define FLAG_REG_ADDR     8'h2B
`define PERIODIC_FLAG_BIT 7
`define ALARM2_FLAG_BIT   6
`define FLAG_RESET_VAL    1'b0
`define PERIODIC_NONE     2'h0
`define PERIODIC_SECOND   2'h1
`define PERIODIC_MINUTE   2'h2
`define PERIODIC_HOUR     2'h3
`define SECS_PER_MIN      6'h3B
`define MINS_PER_HOUR     6'h3B
`endif

// *** logic/rtc_flags_pkg.sv ***
// types of the event flag status register
`default_nettype none
package rtc_flags_pkg;
  typedef logic [1:0] periodic_sel_t;
  typedef struct packed {
    logic       periodic_event_flag;
    logic       second_alarm_flag;
    logic [5:0] sec_cnt;
    logic [5:0] min_cnt;
    logic       pulse;
    logic [7:0] rdata;
    logic       sec_s1;
    logic       sec_s2;
    logic       sec_s3;
    logic       alm_s1;
    logic       alm_s2;
    logic       alm_s3;
  } flag_state_t;
endpackage
`default_nettype wire

// *** test/flag_host.sv ***
// host model reading and writing the flag register
`timescale 1ns/1ps
`default_nettype none
module flag_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output var logic [7:0]  o_addr,
  output var logic        o_wr,
  output var logic        o_rd,
  output var logic [7:0]  o_wdata
);
  initial {o_addr, o_wr, o_rd, o_wdata} = 18'h0;
  // released lines show the inverse, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
    @(posedge i_clk) {o_addr, o_wdata, o_wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_clk) {o_addr, o_rd} <= {a, 1'b1};
    @(posedge i_clk) {o_addr, o_rd} <= {~a, 1'b0};
    #1 q = i_rdata;
  endtask
endmodule
`default_nettype wire

// *** test/rtc_event_flag_status_bench.sv ***
// bench for the event flag status register
`timescale 1ns/1ps
`default_nettype none
module rtc_event_flag_status_bench;
  logic [1:0]  ev = 2'h0, sel = 2'h0;
  logic        i_clk = 0, i_nrst = 0, wr, rd, pf, af, pp;
  logic        ce = 1'b1;
  logic [7:0]  addr, wdata, rdata, q;
  int          err_count = 0, checks = 0, pc = 0;
  // write addr, write data, read addr, expected byte
  logic [31:0] rows [5] = '{32'h2C002BC0, 32'h2BFF2BC0, 32'h2B402B40, 32'h2B002B00, 32'h2B002A00};
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (pp) pc++;
  flag_host host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  rtc_event_flag_status DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_sec_tick(ev[0]),
    .i_alarm2_match(ev[1]), .i_periodic_sel(sel), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
    .o_rdata(rdata), .o_periodic_event_flag(pf), .o_second_alarm_flag(af), .o_periodic_pulse(pp));
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // event lines held 5 cycles each way, above the 1-cycle minimum of the edge detect
  task automatic ev_pulse(input logic [1:0] m);
    repeat (5) @(posedge i_clk);
    ev <= m;
    repeat (5) @(posedge i_clk);
    ev <= 2'h0;
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1;
    host.rd(8'h2B, q);
    cmp("reset read", 8'h00, q);
    @(posedge i_clk) sel <= 2'h1;
    ev_pulse(2'h3);
    cmp("second pulses", 8'h01, 8'(pc));
    ev_pulse(2'h1);
    cmp("pulses with flag set", 8'h02, 8'(pc));
    $display("event test done");
    foreach (rows[i]) begin
      host.wr(rows[i][31:24], rows[i][23:16]);
      host.rd(rows[i][15:8], q);
      cmp("row read", rows[i][7:0], q);
      cmp("flag pins", rows[i][7:0], {pf, af, 6'h00});
    end
    $display("row test done");
    @(posedge i_clk) sel <= 2'h0;
    @(posedge i_clk) sel <= 2'h2;
    pc = 0;
    repeat (59) ev_pulse(2'h1);
    cmp("minute early", 8'h00, 8'(pc));
    ev_pulse(2'h1);
    cmp("minute pulse", 8'h01, 8'(pc));
    $display("minute test done");
    cmp("minute flag", 8'h01, {7'h00, pf});
    // a write while the enable is low must not reach the flags
    @(posedge i_clk) ce <= 1'b0;
    host.wr(8'h2B, 8'h00);
    @(posedge i_clk) ce <= 1'b1;
    cmp("frozen flag", 8'h01, {7'h00, pf});
    $display("enable test done");
    @(posedge i_clk) i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    host.rd(8'h2B, q);
    cmp("reset flags", 8'h00, q);
    cmp("reset pins", 8'h00, {pf, af, 6'h00});
    $display("reset test done");
    stop_test();
  end
endmodule
`default_nettype wire

// *** test/rtc_flags_properties.sv ***
// assertions on the flag register ports
`timescale 1ns/1ps
`default_nettype none
module rtc_flags_properties (
  input wire logic       i_clk, i_nrst, i_ce, i_alarm2_match, i_wr, i_rd,
  input wire logic [7:0] i_addr, i_wdata, o_rdata,
  input wire logic       o_periodic_event_flag, o_second_alarm_flag, o_periodic_pulse
);
  wire rf = i_ce && i_rd && i_addr == 8'h2B;
  wire wf = i_ce && i_wr && i_addr == 8'h2B;
  wire pf = o_periodic_event_flag;
  wire af = o_second_alarm_flag;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence alarm_rise; !i_alarm2_match ##1 i_alarm2_match; endsequence
  a_read_flags: assert property (rf |=> o_rdata == {$past(pf), $past(af), 6'h00}) else $error("flag read");
  a_unmapped_zero: assert property (i_ce && i_rd && !rf |=> o_rdata == 8'h00) else $error("unmapped read");
  // a same-cycle set wins, seen as the pulse
  a_clear_periodic: assert property (wf && !i_wdata[7] |=> !pf || o_periodic_pulse) else $error("pf kept");
  a_keep_periodic: assert property (wf && i_wdata[7] && pf |=> pf) else $error("pf lost");
  a_clear_alarm: assert property (wf && !i_wdata[6] && !i_alarm2_match && !$past(i_alarm2_match, 3)
    |=> !af) else $error("af kept");
  a_keep_alarm: assert property (wf && i_wdata[6] && af |=> af) else $error("af lost");
  a_pulse_sets_flag: assert property (o_periodic_pulse |-> pf ##1 !o_periodic_pulse) else $error("pulse");
  a_alarm_latency: assert property (alarm_rise |-> ##3 af) else $error("alarm flag late");
endmodule
bind rtc_event_flag_status rtc_flags_properties u_props (.*);
`default_nettype wire
